// *** core/nim_mapper.sv ***
// numeric channel mapper: discovery, bank allocation and run-time scan
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module nim_mapper
	import nim_pkg::*;
#(
	parameter int BANK_DEPTH = BANK_WORDS,
	parameter int UNIT_LIMIT = MAX_UNITS
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	output logic             chain_valid_o,
	output nim_req_s         chain_req_o,
	input  wire nim_rsp_s    chain_rsp_i,
	output logic             err_o,
	output logic             running_o
);

	// the register map is fixed, so the banks cannot grow past it
	// a smaller unit limit only moves the overflow point
	if (BANK_DEPTH != 64 || UNIT_LIMIT < 1 || UNIT_LIMIT > 32) begin : g_chk
		$error("nim_mapper: unsupported BANK_DEPTH or UNIT_LIMIT");
	end

	localparam logic [7:0] DEPTH_W = 8'(BANK_DEPTH);
	localparam logic [5:0] UNITS_W = 6'(UNIT_LIMIT);

	// banks and lane tables are data only and carry no reset
	logic [15:0] in_bank  [BANK_DEPTH];
	logic [15:0] out_bank [BANK_DEPTH];
	nim_lane_s   in_tab   [BANK_DEPTH];
	nim_lane_s   out_tab  [BANK_DEPTH];

	// sequencer state
	nim_state_e  state;
	logic [5:0]  slot;
	logic [3:0]  lane;
	logic [6:0]  in_words;
	logic [6:0]  out_words;
	logic [6:0]  n_in;
	logic [6:0]  n_out;
	logic        phase_out;
	logic [5:0]  ent;
	logic [2:0]  word;
	logic [3:0]  err_code;
	logic        enable;

	// combinational terms
	logic        restart;
	logic        probe_ack;
	logic        scan_ack;
	logic        take_in;
	logic        take_out;
	logic        in_fits;
	logic        out_fits;
	nim_lane_s   cur;
	logic [5:0]  cur_idx;
	logic [6:0]  n_cur;
	logic [7:0]  in_sum;
	logic [7:0]  out_sum;
	logic        lane_done;
	logic        ent_last;
	logic        in_hit;
	logic        out_hit;
	logic [5:0]  in_off;
	logic [5:0]  out_off;

	// handshake and decode terms
	assign restart   = reg_wr_i && reg_addr_i == REG_CTRL
		&& reg_wdata_i[CTRL_RESTART_BIT];
	assign probe_ack = state == NIM_ST_PROBE_WAIT && chain_rsp_i.ack;
	assign scan_ack  = state == NIM_ST_SCAN_WAIT && chain_rsp_i.ack;
	assign chain_valid_o = state == NIM_ST_PROBE_WAIT
		|| state == NIM_ST_SCAN_WAIT;
	assign err_o     = err_code != ERR_NONE;
	assign running_o = state == NIM_ST_SCAN || state == NIM_ST_SCAN_WAIT;

	// running word totals if the answering lane were accepted
	assign in_sum  = {1'b0, in_words} + {5'h00, chain_rsp_i.words};
	assign out_sum = {1'b0, out_words} + {5'h00, chain_rsp_i.words};

	// a lane is only taken when it fits in its own bank; a lane of no
	// words owns no bank word, so it is never entered or scanned
	assign in_fits  = in_sum <= DEPTH_W;
	assign out_fits = out_sum <= DEPTH_W;
	assign take_in  = probe_ack && chain_rsp_i.present && slot < UNITS_W
		&& chain_rsp_i.kind == NIM_KIND_WORD_INPUT
		&& chain_rsp_i.words != 3'h0 && in_fits;
	assign take_out = probe_ack && chain_rsp_i.present && slot < UNITS_W
		&& chain_rsp_i.kind == NIM_KIND_WORD_OUTPUT
		&& chain_rsp_i.words != 3'h0 && out_fits;

	// scan position: current lane and the bank word it reaches
	assign cur       = phase_out ? out_tab[ent] : in_tab[ent];
	assign n_cur     = phase_out ? n_out : n_in;
	assign cur_idx   = cur.base + {3'h0, word};
	assign lane_done = {1'b0, word} + 4'h1 >= {1'b0, cur.words};
	assign ent_last  = {1'b0, ent} + 7'h01 >= n_cur;

	// register port decode
	assign in_hit  = reg_addr_i >= REG_IN_FIRST && reg_addr_i <= REG_IN_LAST;
	assign out_hit = reg_addr_i >= REG_OUT_FIRST
		&& reg_addr_i <= REG_OUT_LAST;
	assign in_off  = 6'(reg_addr_i - REG_IN_FIRST);
	assign out_off = 6'(reg_addr_i - REG_OUT_FIRST);

	// sequencer: probe every slot and lane, then scan lanes for ever
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || restart) begin
			state     <= NIM_ST_PROBE;
			slot      <= 6'h00;
			lane      <= 4'h0;
			in_words  <= 7'h00;
			out_words <= 7'h00;
			n_in      <= 7'h00;
			n_out     <= 7'h00;
			phase_out <= 1'b0;
			ent       <= 6'h00;
			word      <= 3'h0;
			err_code  <= ERR_NONE;
		end else begin
			case (state)
				// one identify request per lane, slot and lane hold still
				NIM_ST_PROBE: begin
					state <= NIM_ST_PROBE_WAIT;
				end
				// the first absent answer ends the chain, gaps are not bridged
				NIM_ST_PROBE_WAIT: begin
					if (chain_rsp_i.ack) begin
						if (!chain_rsp_i.present) begin
							state <= NIM_ST_SCAN;
						end else if (slot >= UNITS_W) begin
							err_code <= ERR_UNITS;
							state    <= NIM_ST_HALT;
						end else if (chain_rsp_i.kind == NIM_KIND_WORD_INPUT
							&& !in_fits) begin
							err_code <= ERR_WORDS;
							state    <= NIM_ST_HALT;
						end else if (chain_rsp_i.kind == NIM_KIND_WORD_OUTPUT
							&& !out_fits) begin
							err_code <= ERR_WORDS;
							state    <= NIM_ST_HALT;
						end else begin
							state <= NIM_ST_PROBE;
							if (take_in) begin
								in_words <= in_sum[6:0];
								n_in     <= n_in + 7'h01;
							end
							if (take_out) begin
								out_words <= out_sum[6:0];
								n_out     <= n_out + 7'h01;
							end
							// a lane field of 4 bits caps a module at 16 lanes
							if (chain_rsp_i.last || lane == 4'hf) begin
								slot <= slot + 6'h01;
								lane <= 4'h0;
							end else begin
								lane <= lane + 4'h1;
							end
						end
					end
				end
				// a cleared enable parks here, between transfers, never inside
				NIM_ST_SCAN: begin
					if (enable) begin
						if (n_cur == 7'h00) begin
							phase_out <= !phase_out;      // empty side: skip it
							ent       <= 6'h00;
							word      <= 3'h0;
						end else begin
							state <= NIM_ST_SCAN_WAIT;
						end
					end
				end
				// no timeout: a module that never answers stalls the scan
				NIM_ST_SCAN_WAIT: begin
					if (chain_rsp_i.ack) begin
						state <= NIM_ST_SCAN;
						if (lane_done) begin
							word <= 3'h0;
							if (ent_last) begin
								ent       <= 6'h00;
								phase_out <= !phase_out;
							end else begin
								ent <= ent + 6'h01;
							end
						end else begin
							word <= word + 3'h1;
						end
					end
				end
				// halt: only reset or a restart leaves it
				default: begin
					state <= NIM_ST_HALT;                 // stays until restart
				end
			endcase
		end
	end

	// lane tables, written once per accepted lane during discovery
	// entries past the lane counts are never read, so stale ones are harmless
	always_ff @(posedge core_clk_i) begin
		if (take_in) begin
			in_tab[n_in[5:0]] <= '{slot: slot, lane: lane,
				words: chain_rsp_i.words, base: in_words[5:0]};
		end
		if (take_out) begin
			out_tab[n_out[5:0]] <= '{slot: slot, lane: lane,
				words: chain_rsp_i.words, base: out_words[5:0]};
		end
	end

	// input bank: only words owned by a lane are ever refreshed
	always_ff @(posedge core_clk_i) begin
		if (scan_ack && !phase_out) begin
			in_bank[cur_idx] <= chain_rsp_i.data;
		end
	end

	// output bank: software owned, the scan only reads it
	always_ff @(posedge core_clk_i) begin
		if (reg_wr_i && out_hit) begin
			out_bank[out_off] <= reg_wdata_i;
		end
	end

	// request word, loaded on the same edge that raises valid
	// fields of a finished request linger; valid alone qualifies them
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			chain_req_o <= '0;
		end else if (state == NIM_ST_PROBE) begin
			chain_req_o <= '{op: NIM_OP_IDENT, slot: slot, lane: lane,
				word: 3'h0, data: 16'h0000};
		end else if (state == NIM_ST_SCAN && enable && n_cur != 7'h00) begin
			// the output word is sampled at issue, a later write waits a pass
			chain_req_o <= '{op: phase_out ? NIM_OP_SEND : NIM_OP_FETCH,
				slot: cur.slot, lane: cur.lane, word: word,
				data: phase_out ? out_bank[cur_idx] : 16'h0000};
		end
	end

	// run enable; restart is a self-clearing command bit
	// pausing leaves the register port live, outputs may still be updated
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			enable <= CTRL_ENABLE_RESET;
		end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
			enable <= reg_wdata_i[CTRL_ENABLE_BIT];
		end
	end

	// read data stand for exactly one cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || !reg_rd_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (in_hit) begin
			reg_rdata_o <= in_bank[in_off];
		end else if (out_hit) begin
			reg_rdata_o <= out_bank[out_off];
		end else if (reg_addr_i == REG_STATUS) begin
			// status and count are snapshots taken at the strobe edge
			reg_rdata_o <= 16'h0000;
			reg_rdata_o[STAT_ERR_LSB +: 4] <= err_code;
			reg_rdata_o[STAT_RUN_BIT]      <= running_o;
			reg_rdata_o[STAT_HALT_BIT]     <= state == NIM_ST_HALT;
		end else if (reg_addr_i == REG_COUNT) begin
			reg_rdata_o <= 16'h0000;
			reg_rdata_o[6:0] <= in_words;
			reg_rdata_o[CNT_OUT_LSB +: 7] <= out_words;
		end else if (reg_addr_i == REG_CTRL) begin
			reg_rdata_o <= 16'h0000;
			reg_rdata_o[CTRL_ENABLE_BIT] <= enable;
		end else begin
			reg_rdata_o <= 16'h0000;                      // unmapped reads zero
		end
	end

endmodule
`default_nettype wire

// *** core/nim_pkg.sv ***
// shared constants and types of the numeric channel mapper
package nim_pkg;
	// register numbers double as word addresses on the register port
	localparam logic [11:0] REG_IN_FIRST  = 12'hf00; // 3840
	localparam logic [11:0] REG_IN_LAST   = 12'hf3f; // 3903
	localparam logic [11:0] REG_OUT_FIRST = 12'hf40; // 3904
	localparam logic [11:0] REG_OUT_LAST  = 12'hf7f; // 3967
	localparam logic [11:0] REG_CTRL      = 12'hfd0;
	localparam logic [11:0] REG_STATUS    = 12'hfd1; // 4049
	localparam logic [11:0] REG_COUNT     = 12'hfd2;

	localparam int BANK_WORDS = 64;
	localparam int MAX_UNITS  = 32;

	// status fields
	localparam int STAT_ERR_LSB  = 0;
	localparam int STAT_RUN_BIT  = 4;
	localparam int STAT_HALT_BIT = 5;
	// count register: input words low, output words from this bit
	localparam int CNT_OUT_LSB   = 8;
	// control fields
	localparam int CTRL_RESTART_BIT = 0;
	localparam int CTRL_ENABLE_BIT  = 1;
	localparam logic CTRL_ENABLE_RESET = 1'b1;

	localparam logic [3:0] ERR_NONE  = 4'h0;
	localparam logic [3:0] ERR_WORDS = 4'h1;
	localparam logic [3:0] ERR_UNITS = 4'h2;

	typedef enum logic [1:0] {
		NIM_KIND_NONE,
		NIM_KIND_BIT_POINTS,
		NIM_KIND_WORD_INPUT,
		NIM_KIND_WORD_OUTPUT
	} nim_kind_e;

	typedef enum logic [1:0] {
		NIM_OP_IDENT,
		NIM_OP_FETCH,
		NIM_OP_SEND
	} nim_op_e;

	typedef enum logic [2:0] {
		NIM_ST_PROBE,
		NIM_ST_PROBE_WAIT,
		NIM_ST_SCAN,
		NIM_ST_SCAN_WAIT,
		NIM_ST_HALT
	} nim_state_e;

	// request toward the expansion chain
	typedef struct packed {
		nim_op_e     op;
		logic [5:0]  slot;
		logic [3:0]  lane;
		logic [2:0]  word;
		logic [15:0] data;
	} nim_req_s;

	// answer from the expansion chain
	typedef struct packed {
		logic        ack;
		logic        present;
		nim_kind_e   kind;
		logic [2:0]  words;
		logic        last;
		logic [15:0] data;
	} nim_rsp_s;

	// one allocated signal_lane
	typedef struct packed {
		logic [5:0] slot;
		logic [3:0] lane;
		logic [2:0] words;
		logic [5:0] base;
	} nim_lane_s;
endpackage

// *** sim/nim_mapper_asserts.sv ***
// port checker for the numeric channel mapper
`timescale 1ns/1ps
`default_nettype none
module nim_mapper_asserts
	import nim_pkg::*;
#(
	parameter int UNIT_LIMIT = MAX_UNITS
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_rdata_o,
	input  wire logic        chain_valid_o,
	input  wire nim_req_s    chain_req_o,
	input  wire nim_rsp_s    chain_rsp_i,
	input  wire logic        err_o,
	input  wire logic        running_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// a restart may withdraw a pending request, so it is excused here
	AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
		else $error("read data outside its slot");
	AST_REQ_HOLD: assert property (chain_valid_o && !chain_rsp_i.ack
		&& !(reg_wr_i && reg_addr_i == REG_CTRL)
		|=> chain_valid_o && $stable(chain_req_o))
		else $error("request changed before answer");
	AST_REQ_DROP: assert property (chain_valid_o && chain_rsp_i.ack |=> !chain_valid_o)
		else $error("request kept after answer");
	AST_FIRST_PROBE: assert property ($rose(reset_n_i) |-> ##[1:2]
		(chain_valid_o && chain_req_o.op == NIM_OP_IDENT
		&& chain_req_o.slot == 6'h0 && chain_req_o.lane == 4'h0))
		else $error("discovery does not start at first slot");
	AST_SCAN_RUN: assert property (chain_valid_o && chain_req_o.op != NIM_OP_IDENT |-> running_o)
		else $error("transfer outside scan");
	AST_PROBE_STOP: assert property (chain_valid_o && chain_req_o.op == NIM_OP_IDENT |-> !running_o)
		else $error("probe while scanning");
	AST_SLOT_BOUND: assert property (chain_valid_o && running_o |-> 32'(chain_req_o.slot) < UNIT_LIMIT)
		else $error("scan beyond module limit");
	AST_ERR_QUIET: assert property (err_o |-> !chain_valid_o && !running_o)
		else $error("traffic while halted");
	AST_ERR_STICKY: assert property (err_o && !(reg_wr_i && reg_addr_i == REG_CTRL) |=> err_o)
		else $error("error cleared without restart");
endmodule
bind nim_mapper nim_mapper_asserts #(.UNIT_LIMIT(UNIT_LIMIT)) u_chk (
	.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .chain_valid_o, .chain_req_o, .chain_rsp_i, .err_o, .running_o
);
`default_nettype wire

// *** sim/nim_chain_model.sv ***
// behavioural chain of expansion modules facing the mapper
`timescale 1ns/1ps
`default_nettype none
module nim_chain_model
	import nim_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       valid_i,
	input  wire nim_req_s   req_i,
	output nim_rsp_s        rsp_o
);
	logic        ack;
	logic [1:0]  cnt;
	logic [15:0] val;
	logic [15:0] sent [0:127];
	assign val = {4'ha, req_i.slot[3:0], req_i.lane, 1'b0, req_i.word};
	// mode 0 mixed chain, 1 endless chain, 2 too many input words
	always_comb begin
		rsp_o = '0;
		rsp_o.ack = ack;
		rsp_o.data = ack ? val : ~val; // val while ack is high, its inverse otherwise
		if (mode_i == 2'd0) begin
			rsp_o.present = req_i.slot < 6'h3;
			rsp_o.kind = nim_kind_e'(req_i.slot[1:0] + 2'd1);
			rsp_o.words = {1'b0, req_i.slot[1:0]} + {2'b0, req_i.lane[0]};
			rsp_o.last = req_i.slot != 6'h1 || req_i.lane[0];
		end else begin
			rsp_o.present = mode_i == 2'd1 || req_i.slot == 6'h0;
			rsp_o.kind = mode_i == 2'd1 ? NIM_KIND_BIT_POINTS : NIM_KIND_WORD_INPUT;
			rsp_o.words = 3'd7;
			rsp_o.last = mode_i == 2'd1 || req_i.lane == 4'hf;
		end
	end
	// answer after one to four cycles so both quick and slow paths run
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !valid_i || ack) begin
			ack <= 1'b0;
			cnt <= 2'd0;
		end else if (cnt == (req_i.slot[1:0] ^ req_i.word[1:0])) begin
			ack <= 1'b1;
		end else begin
			cnt <= cnt + 2'd1;
		end
	end
	// keep each word delivered to an output lane
	always_ff @(posedge clk_i) begin
		if (ack && valid_i && req_i.op == NIM_OP_SEND) begin
			sent[{req_i.lane, req_i.word}] <= req_i.data;
		end
	end
endmodule
`default_nettype wire

// *** sim/nim_mapper_test.sv ***
// self-checking bench for the numeric channel mapper
`timescale 1ns/1ps
`default_nettype none
module nim_mapper_test
	import nim_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [11:0] reg_addr = 12'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        valid;
	logic        err;
	logic        running;
	logic [1:0]  mode = 2'd0;
	nim_req_s    req;
	nim_rsp_s    rsp;
	int          error_cnt = 0;
	int          samples_checked = 0;
	always #25 clk = ~clk;
	// unit limit cut to four so the module overflow comes quickly
	nim_mapper #(.UNIT_LIMIT(4)) dut (.core_clk_i(clk), .reset_n_i(reset_n),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .chain_valid_o(valid),
		.chain_req_o(req), .chain_rsp_i(rsp), .err_o(err), .running_o(running));
	nim_chain_model u_chain (.clk_i(clk), .reset_n_i(reset_n), .mode_i(mode),
		.valid_i(valid), .req_i(req), .rsp_o(rsp));
	task automatic close_out();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, e);
	endtask
	// bounded wait for scan or error, then 100 cycles more
	task automatic settle(input bit want_err);
		repeat (2) @(posedge clk);
		for (int i = 0; i < 3000 && (want_err ? err : running) !== 1'b1; i++)
			@(posedge clk);
		repeat (100) @(posedge clk);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		settle(1'b0);
		rd(REG_STATUS, 16'h0010);
		cmp({15'h0, running}, 16'h0001);
		rd(REG_COUNT, 16'h0203);
		wr(REG_IN_FIRST, 16'h5555);
		rd(REG_IN_FIRST, 16'ha100);
		rd(REG_IN_FIRST + 12'h1, 16'ha110);
		rd(REG_IN_FIRST + 12'h2, 16'ha111);
		for (int i = 0; i < 2; i++) begin
			wr(REG_OUT_FIRST + 12'(i), 16'hb000 + 16'(i));
		end
		repeat (100) @(posedge clk);
		for (int i = 0; i < 2; i++) begin
			cmp(u_chain.sent[i], 16'hb000 + 16'(i));
		end
		rd(REG_OUT_FIRST + 12'h1, 16'hb001);
		// pause the scan: a new output word must wait for the resume
		wr(REG_CTRL, 16'h0000);
		rd(REG_CTRL, 16'h0000);
		wr(REG_OUT_FIRST, 16'hc000);
		repeat (100) @(posedge clk);
		cmp(u_chain.sent[0], 16'hb000);
		wr(REG_CTRL, 16'h0002);
		rd(REG_CTRL, 16'h0002);
		repeat (100) @(posedge clk);
		cmp(u_chain.sent[0], 16'hc000);
		rd(12'h800, 16'h0000);
		mode <= 2'd1;
		wr(REG_CTRL, 16'h0003);
		settle(1'b1);
		rd(REG_STATUS, 16'h0022);
		mode <= 2'd2;
		wr(REG_CTRL, 16'h0003);
		settle(1'b1);
		rd(REG_STATUS, 16'h0021);
		cmp({15'h0, err}, 16'h0001);
		close_out();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end
endmodule
`default_nettype wire
